// file: core/tcp_pkg.sv
package tcp_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TCP_GTC_OFFSET    = 8'h00;
  localparam logic [7:0] TCP_CSEL_OFFSET   = 8'h04;
  localparam logic [7:0] TCP_STATUS_OFFSET = 8'h08;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int         TCP_SYNC_HOLD_BIT = 7;
  localparam int         TCP_PSR_BIT       = 0;
  localparam int         TCP_CSEL_W        = 3;
  localparam int         TCP_PRE_W         = 10;
  localparam logic [7:0] TCP_GTC_RESET     = 8'h00;
  localparam logic [2:0] TCP_CSEL_RESET    = 3'h0;
  // ----------------------------------------------------------------
  // clock select codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TCP_CS_STOP  = 3'h0,
    TCP_CS_DIRECT = 3'h1,
    TCP_CS_DIV8  = 3'h2,
    TCP_CS_DIV64 = 3'h3,
    TCP_CS_DIV256 = 3'h4,
    TCP_CS_DIV1024 = 3'h5,
    TCP_CS_EXT_FALL = 3'h6,
    TCP_CS_EXT_RISE = 3'h7
  } tcp_csel_e;
  // prescaler tap bit: tick when bits below wrap
  localparam int TCP_TAP8    = 3;
  localparam int TCP_TAP64   = 6;
  localparam int TCP_TAP256  = 8;
  localparam int TCP_TAP1024 = 10;
  localparam logic [1:0] TCP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TCP_RESP_SLVERR = 2'h2;
endpackage : tcp_pkg

// file: core/tcp_ext_sync.sv
`timescale 1ns/100ps
module tcp_ext_sync
  import tcp_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic pin,
  output logic      sync_level,
  output logic      sync_prev
);
  logic s1_reg, s2_reg, s3_reg;
  logic s1_next, s2_next, s3_next;
  // ----------------------------------------------------------------
  // two-flop synchroniser, third flop for edge history
  // ----------------------------------------------------------------
  always_comb begin
    s1_next = ce ? pin : s1_reg;
    s2_next = ce ? s1_reg : s2_reg;
    s3_next = ce ? s2_reg : s3_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end
  assign sync_level = s2_reg;
  assign sync_prev  = s3_reg;
endmodule : tcp_ext_sync

// file: core/tcp_timer_clock_prescaler.sv
`timescale 1ns/100ps
// How it works
// - select 1 ticks every clock
// - taps divide by 8, 64, 256, 1024
// - prescaler free-runs regardless of select
// - first prescaled tick within 1..N cycles of select change
// - input synchronised by clocked flops
// - one tick per rising/falling edge
// - tick 2 to 3 cycles after edge
// - external input never prescaled
// - hold mode keeps prescaler reset bit
// - clearing hold mode clears reset bit
// - reset bit self clears without hold
// - select 0 gives no tick
// - pin counts even when driven locally
module tcp_timer_clock_prescaler
  import tcp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        ext_count_input,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             count_tick,
  output logic             ext_count_tick
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              sync_hold_mode_reg, sync_hold_mode_next;
  logic              prescaler_reset_bit_reg, prescaler_reset_bit_next;
  logic [2:0]        count_clock_select_reg, count_clock_select_next;
  logic [TCP_PRE_W-1:0] pre_reg, pre_next;
  logic              tick_reg, tick_next;
  logic              ext_tick_reg, ext_tick_next;
  logic              aw_hold_reg, aw_hold_next;
  logic              w_hold_reg, w_hold_next;
  logic [7:0]        awaddr_reg, awaddr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic              wstrb0_reg, wstrb0_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic              sync_level, sync_prev;
  logic              pre_clear;
  logic              wr_fire, rd_fire;
  logic [TCP_PRE_W:0] pre_inc;
  logic              rise_seen, fall_seen;

  // ----------------------------------------------------------------
  // external pin synchroniser
  // ----------------------------------------------------------------
  // clocked sampling
  tcp_ext_sync u_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (clk_en),
    .pin        (ext_count_input),
    .sync_level (sync_level),
    .sync_prev  (sync_prev)
  );

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  assign wr_fire = (aw_hold_reg && w_hold_reg) && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (awaddr_reg == TCP_GTC_OFFSET || awaddr_reg == TCP_CSEL_OFFSET ||
                      awaddr_reg == TCP_STATUS_OFFSET) ? TCP_RESP_OKAY : TCP_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = TCP_RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        TCP_GTC_OFFSET:
          rdata_next = {24'h0, sync_hold_mode_reg, 6'h0, prescaler_reset_bit_reg};
        TCP_CSEL_OFFSET:
          rdata_next = {29'h0, count_clock_select_reg};
        TCP_STATUS_OFFSET:
          rdata_next = {21'h0, sync_level, pre_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = TCP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_comb begin
    sync_hold_mode_next      = sync_hold_mode_reg;
    prescaler_reset_bit_next = prescaler_reset_bit_reg;
    count_clock_select_next  = count_clock_select_reg;
    if (!sync_hold_mode_reg)
      prescaler_reset_bit_next = 1'b0;
    if (wr_fire && wstrb0_reg && awaddr_reg == TCP_GTC_OFFSET) begin
      sync_hold_mode_next = wdata_reg[TCP_SYNC_HOLD_BIT];
      if (wdata_reg[TCP_SYNC_HOLD_BIT])
        prescaler_reset_bit_next = wdata_reg[TCP_PSR_BIT] | prescaler_reset_bit_reg;
      else
        prescaler_reset_bit_next = 1'b0;
    end
    if (wr_fire && wstrb0_reg && awaddr_reg == TCP_CSEL_OFFSET)
      count_clock_select_next = wdata_reg[TCP_CSEL_W-1:0];
  end

  // a written one resets the prescaler in the write cycle itself
  assign pre_clear = prescaler_reset_bit_reg ||
                     (wr_fire && wstrb0_reg && awaddr_reg == TCP_GTC_OFFSET &&
                      wdata_reg[TCP_PSR_BIT]);

  // ----------------------------------------------------------------
  // prescaler and tick selection
  // ----------------------------------------------------------------
  assign pre_inc   = {1'b0, pre_reg} + {{TCP_PRE_W{1'b0}}, 1'b1};
  assign rise_seen = sync_level && !sync_prev;
  assign fall_seen = !sync_level && sync_prev;

  always_comb begin
    pre_next = pre_clear ? '0 : pre_inc[TCP_PRE_W-1:0];
    // one pulse per edge, from the synchronised pin
    ext_tick_next = ((count_clock_select_reg == TCP_CS_EXT_RISE) && rise_seen) ||
                    ((count_clock_select_reg == TCP_CS_EXT_FALL) && fall_seen);
    // tap fires when lower bits wrap
    unique case (tcp_csel_e'(count_clock_select_reg))
      TCP_CS_STOP:     tick_next = 1'b0;
      TCP_CS_DIRECT:   tick_next = 1'b1;
      TCP_CS_DIV8:     tick_next = !pre_clear && (&pre_reg[TCP_TAP8-1:0]);
      TCP_CS_DIV64:    tick_next = !pre_clear && (&pre_reg[TCP_TAP64-1:0]);
      TCP_CS_DIV256:   tick_next = !pre_clear && (&pre_reg[TCP_TAP256-1:0]);
      TCP_CS_DIV1024:  tick_next = !pre_clear && (&pre_reg[TCP_TAP1024-1:0]);
      TCP_CS_EXT_FALL: tick_next = ext_tick_next;
      TCP_CS_EXT_RISE: tick_next = ext_tick_next;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_hold_mode_reg      <= TCP_GTC_RESET[TCP_SYNC_HOLD_BIT];
      prescaler_reset_bit_reg <= TCP_GTC_RESET[TCP_PSR_BIT];
      count_clock_select_reg  <= TCP_CSEL_RESET;
      pre_reg                 <= '0;
      tick_reg                <= 1'b0;
      ext_tick_reg            <= 1'b0;
      aw_hold_reg             <= 1'b0;
      w_hold_reg              <= 1'b0;
      awaddr_reg              <= 8'h00;
      wdata_reg               <= 32'h0;
      wstrb0_reg              <= 1'b0;
      bvalid_reg              <= 1'b0;
      bresp_reg               <= TCP_RESP_OKAY;
      rvalid_reg              <= 1'b0;
      rdata_reg               <= 32'h0;
      rresp_reg               <= TCP_RESP_OKAY;
    end else if (clk_en) begin
      sync_hold_mode_reg      <= sync_hold_mode_next;
      prescaler_reset_bit_reg <= prescaler_reset_bit_next;
      count_clock_select_reg  <= count_clock_select_next;
      pre_reg                 <= pre_next;
      tick_reg                <= tick_next;
      ext_tick_reg            <= ext_tick_next;
      aw_hold_reg             <= aw_hold_next;
      w_hold_reg              <= w_hold_next;
      awaddr_reg              <= awaddr_next;
      wdata_reg               <= wdata_next;
      wstrb0_reg              <= wstrb0_next;
      bvalid_reg              <= bvalid_next;
      bresp_reg               <= bresp_next;
      rvalid_reg              <= rvalid_next;
      rdata_reg               <= rdata_next;
      rresp_reg               <= rresp_next;
    end
  end

  assign s_axi_awready  = !aw_hold_reg;
  assign s_axi_wready   = !w_hold_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = !rvalid_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;
  assign count_tick     = tick_reg;
  assign ext_count_tick = ext_tick_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_direct_tick_every: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && count_clock_select_reg == TCP_CS_DIRECT) |=> count_tick)
    else $error("direct select missed a tick");
  chk_stop_no_tick: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && count_clock_select_reg == TCP_CS_STOP) |=> !count_tick)
    else $error("tick while stopped");
  chk_div8_spacing: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (count_tick && count_clock_select_reg == TCP_CS_DIV8 && clk_en && !pre_clear)
      |=> !count_tick [*7])
    else $error("div8 ticks too close");
  chk_prescaler_free_run: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && !pre_clear && $changed(count_clock_select_reg))
      |=> pre_reg == $past(pre_reg) + 10'h1)
    else $error("prescaler disturbed by select");
  chk_psr_self_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && wr_fire && wstrb0_reg && awaddr_reg == TCP_GTC_OFFSET &&
     wdata_reg[TCP_PSR_BIT] && !wdata_reg[TCP_SYNC_HOLD_BIT])
      |=> !prescaler_reset_bit_reg && pre_reg == 10'h0)
    else $error("reset bit did not clear");
  chk_hold_keeps_psr: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && sync_hold_mode_reg && prescaler_reset_bit_reg && !wr_fire)
      |=> prescaler_reset_bit_reg && pre_reg == 10'h0)
    else $error("hold mode lost reset bit");
  chk_hold_exit_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && sync_hold_mode_reg && !sync_hold_mode_next) |=> !prescaler_reset_bit_reg)
    else $error("leaving hold left reset bit set");
  chk_ext_rise_latency: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && count_clock_select_reg == TCP_CS_EXT_RISE && rise_seen) |=> ext_count_tick)
    else $error("rising edge tick missing");
  chk_ext_single_pulse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && ext_count_tick) |=> !(clk_en && ext_count_tick))
    else $error("edge gave two pulses");
endmodule : tcp_timer_clock_prescaler

// file: bench/tcp_ext_src.sv
`timescale 1ns/100ps
module tcp_ext_src (
  input  wire logic       aclk,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  input  wire logic [7:0] half,
  output logic            pin,
  output logic            busy
);
  // pin rests low between bursts, one high and one low phase per pulse
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (start) begin
        busy <= 1'b1;
        // each half period spans several cycles
        repeat (pulses) begin
          pin <= 1'b1;
          repeat (half) @(posedge aclk);
          pin <= 1'b0;
          repeat (half) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : tcp_ext_src

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
  import tcp_pkg::*;
  logic        aclk, aresetn, clk_en, pin, src_start, src_busy;
  logic [7:0]  src_pulses;
  logic [31:0] awaddr, wdata, araddr, rdata, r, s1, s2;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, count_tick, ext_count_tick;
  logic [1:0]  bresp, rresp, rs;
  int          miscompares, check_count, ticks, eticks, cycles, n, tick_base, etick_base;
  tcp_csel_e   div_code [4] = '{TCP_CS_DIV8, TCP_CS_DIV64, TCP_CS_DIV256, TCP_CS_DIV1024};
  int          div_val  [4] = '{8, 64, 256, 1024};

  tcp_timer_clock_prescaler tcp_timer_clock_prescaler_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .ext_count_input(pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_tick(count_tick), .ext_count_tick(ext_count_tick));

  tcp_ext_src tcp_ext_src_inst (
    .aclk(aclk), .start(src_start), .pulses(src_pulses), .half(8'h03),
    .pin(pin), .busy(src_busy));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (count_tick === 1'b1) ticks <= ticks + 1;
    if (ext_count_tick === 1'b1) eticks <= eticks + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    awaddr <= {24'h0, a};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(posedge aclk);
      #1;
      k++;
    end while (count_tick !== 1'b1 && k < 3000);
  endtask : wait_tick

  task automatic tick_delta(input int len, output int d);
    @(posedge aclk);
    tick_base = ticks;
    repeat (len) @(posedge aclk);
    d = ticks - tick_base;
  endtask : tick_delta

  task automatic burst(input logic [7:0] p);
    int k;
    src_pulses <= p;
    src_start <= 1'b1;
    @(posedge aclk);
    src_start <= 1'b0;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (src_busy !== 1'b0 && k < 500);
    repeat (8) @(posedge aclk);
  endtask : burst

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, src_start} = '0;
    {awaddr, wdata, araddr, src_pulses} = '0;
    {miscompares, check_count, ticks, eticks, cycles} = '0;
    clk_en = 1'b1;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(TCP_GTC_OFFSET, r, rs);
    check("ctrl reset", {24'h0, TCP_GTC_RESET}, r);
    axi_read(TCP_CSEL_OFFSET, r, rs);
    check("select reset", {29'h0, TCP_CSEL_RESET}, r);
    check("mapped rresp", {30'h0, TCP_RESP_OKAY}, {30'h0, rs});
    axi_read(8'h0c, r, rs);
    check("unmapped rresp", {30'h0, TCP_RESP_SLVERR}, {30'h0, rs});
    check("unmapped rdata", 32'h0, r);
    axi_write(8'h0c, 32'h1, rs);
    check("unmapped bresp", {30'h0, TCP_RESP_SLVERR}, {30'h0, rs});
    tick_delta(50, n);
    check("stopped ticks", 32'h0, n);
    axi_write(TCP_CSEL_OFFSET, {29'h0, TCP_CS_DIRECT}, rs);
    check("mapped bresp", {30'h0, TCP_RESP_OKAY}, {30'h0, rs});
    tick_delta(20, n);
    check("direct ticks", 32'd20, n);
    for (int i = 0; i < 4; i++) begin
      axi_write(TCP_CSEL_OFFSET, {29'h0, div_code[i]}, rs);
      wait_tick(n);
      check("first tick bound", 32'h1, {31'h0, n <= div_val[i] + 3});
      wait_tick(n);
      check("tap spacing", div_val[i], n);
    end
    axi_write(TCP_CSEL_OFFSET, {29'h0, TCP_CS_STOP}, rs);
    axi_write(TCP_GTC_OFFSET, 32'h1 << TCP_PSR_BIT, rs);
    axi_read(TCP_GTC_OFFSET, r, rs);
    check("reset bit self clear", 32'h0, r);
    wstrb <= 4'h0;
    axi_write(TCP_CSEL_OFFSET, {29'h0, TCP_CS_DIRECT}, rs);
    wstrb <= 4'hf;
    axi_read(TCP_CSEL_OFFSET, r, rs);
    check("masked write", {29'h0, TCP_CS_STOP}, r);
    axi_read(TCP_STATUS_OFFSET, s1, rs);
    axi_read(TCP_STATUS_OFFSET, s2, rs);
    check("prescaler cleared", 32'h1, {31'h0, s1[9:0] < 10'd40});
    check("prescaler runs", 32'h1, {31'h0, s2[9:0] > s1[9:0]});
    check("pin idle level", 32'h0, {31'h0, s1[10]});
    axi_read(TCP_STATUS_OFFSET, s1, rs);
    clk_en <= 1'b0;
    repeat (20) @(posedge aclk);
    clk_en <= 1'b1;
    axi_read(TCP_STATUS_OFFSET, s2, rs);
    check("frozen prescaler", 32'h1, {31'h0, (s2[9:0] - s1[9:0]) < 10'd8});
    axi_write(TCP_GTC_OFFSET, 32'h81, rs);
    axi_read(TCP_GTC_OFFSET, r, rs);
    check("hold keeps bit", 32'h81, r);
    axi_write(TCP_CSEL_OFFSET, {29'h0, TCP_CS_DIV8}, rs);
    tick_delta(40, n);
    check("held ticks", 32'h0, n);
    axi_read(TCP_STATUS_OFFSET, r, rs);
    check("held prescaler", 32'h0, {22'h0, r[9:0]});
    axi_write(TCP_GTC_OFFSET, 32'h0, rs);
    axi_read(TCP_GTC_OFFSET, r, rs);
    check("hold release", 32'h0, r);
    wait_tick(n);
    wait_tick(n);
    check("resumed spacing", 32'd8, n);
    // pin idles low across every select change
    for (int m = 0; m < 2; m++) begin
      axi_write(TCP_CSEL_OFFSET, {29'h0, m ? TCP_CS_EXT_FALL : TCP_CS_EXT_RISE}, rs);
      tick_base = ticks;
      etick_base = eticks;
      burst(8'd5);
      check("edge ticks", 32'd5, eticks - etick_base);
      check("undivided count", 32'd5, ticks - tick_base);
    end
    axi_write(TCP_CSEL_OFFSET, {29'h0, TCP_CS_EXT_RISE}, rs);
    src_pulses <= 8'd1;
    src_start <= 1'b1;
    @(posedge pin);
    src_start <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (ext_count_tick !== 1'b1 && n < 20);
    check("edge latency", 32'd3, n);
    repeat (10) @(posedge aclk);
    summarize();
  end
endmodule : tb
